// [boost_cfg_pkg.sv]
// Purpose: shared constants and carriers for the boost mode and phase configuration block
// Assumes: 8-bit register space, one access per strobe
// Notes: offsets of control and diagnostic registers sit outside the phase map
package boost_cfg_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NUM_VPH = 4;
  localparam int NUM_PHYS = 2;
  localparam int NUM_OUT = 2;

  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_PHYS_ON = 8'h01;
  localparam logic [7:0] OFS_PHYS_OUT_MAP = 8'h02;
  localparam logic [7:0] OFS_OUT1_VPH_EN = 8'h0b;
  localparam logic [7:0] OFS_OUT2_VPH_EN = 8'h0c;
  localparam logic [7:0] OFS_PHYS_GEN_MAP = 8'h0f;
  localparam logic [7:0] OFS_DRV_ROUTE = 8'h10;
  localparam logic [7:0] OFS_DIAG = 8'h20;

  // field positions
  localparam int CTRL_OUT1_ON_BIT = 0;
  localparam int CTRL_OUT2_ON_BIT = 1;
  localparam int CTRL_CFG_DONE_BIT = 7;
  localparam int DIAG_SUPPLY_GOOD_BIT = 0;
  localparam int DIAG_SUPPLY_ON_BIT = 1;
  localparam int DIAG_MODE_LSB = 2;
  localparam int DIAG_FAULT_LSB = 4;

  // writable field masks; reserved bits are dropped on write and read as zero
  localparam logic [7:0] MASK_CONTROL = 8'h83;
  localparam logic [7:0] MASK_TWO_BITS = 8'h03;
  localparam logic [7:0] MASK_FOUR_BITS = 8'h0f;

  localparam logic [7:0] RST_REG = 8'h00;

  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_CONFIG,
    MODE_OPERATION,
    MODE_FAIL_SILENT
  } mode_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic over_temp;
    logic supply_err;
    logic vin_under;
    logic vin_over;
  } fault_s;

endpackage

// [boost_mode_and_phase_config.sv]
// Purpose: mode control, register access gating and phase routing of a two-phase boost
// Assumes: register strobes come from a serial framer on the same clock; inputs synchronous
// Notes: registers stand at their printed offsets; control at 0x00, diagnostics at 0x20
// Overview of operation
// - low supply or enable low forces off
// - off mode disables interface and outputs
// - input supply ok and enable high enters configuration
// - configuration: config writable, diagnostics read-only, outputs off
// - configuration: supply follows output enable bits
// - done flag enters operation, locks configuration
// - operation: config read-only, outputs follow registers
// - output enable starts supply, outputs after good
// - battery monitor only while converters run
// - faults move operation to fail-silent
// - fail-silent: outputs, supply off; interface alive
// - fail-silent left only through off: enable low or input supply loss
// - fail-silent: clearing done flag unlocks configuration
// - up to four virtual phases per output
// - output one phase enables in bits 3:0
// - output two phase enables, same layout
// - physical phase to output association bits
// - physical phase to generator association bits
// - two-bit route code picks virtual phase
// - physical phase enable bits 1:0
`timescale 1ns/100ps
module boost_mode_and_phase_config #(
  parameter int NUM_VPH = boost_cfg_pkg::NUM_VPH,
  parameter int NUM_PHYS = boost_cfg_pkg::NUM_PHYS
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic enable_pin_i,
  input wire logic vin_pon_ok_i,
  input wire boost_cfg_pkg::fault_s fault_i,
  input wire logic supply_good_i,
  input wire boost_cfg_pkg::reg_req_s req_i,
  input wire logic [NUM_VPH-1:0] out1_vph_i,
  input wire logic [NUM_VPH-1:0] out2_vph_i,
  output logic [boost_cfg_pkg::DATA_W-1:0] rdata_o,
  output logic rvalid_o,
  output logic serial_on_o,
  output logic gate_supply_on_o,
  output logic [1:0] output_run_o,
  output logic [NUM_PHYS-1:0] gate_drive_o,
  output logic battery_monitor_on_o,
  output boost_cfg_pkg::mode_e mode_o
);
  import boost_cfg_pkg::*;

  mode_e mode_r;
  mode_e mode_nxt;

  logic first_output_on_bit_r;
  logic second_output_on_bit_r;
  logic configuration_complete_flag_r;
  logic [1:0] phys_on_r;
  logic [1:0] physical_phase_output_map_r;
  logic [3:0] output1_virtual_phase_enables_r;
  logic [3:0] output2_virtual_phase_enables_r;
  logic [1:0] physical_phase_generator_map_r;
  logic [3:0] driver_virtual_phase_route_r;

  logic cfg_locked;
  logic is_cfg_reg;
  logic cfg_wr_ok;
  logic ctrl_wr;
  logic any_fault;
  logic drive_kill;
  logic supply_on_c;
  logic [1:0] out_run_c;
  logic [NUM_PHYS-1:0] gate_c;
  logic [7:0] rd_mux;

  // decoding used by the write gate only; the read path decodes addresses itself
  function automatic logic cfg_addr(input logic [7:0] a);
    return (a == OFS_PHYS_ON) || (a == OFS_PHYS_OUT_MAP) || (a == OFS_OUT1_VPH_EN) ||
           (a == OFS_OUT2_VPH_EN) || (a == OFS_PHYS_GEN_MAP) || (a == OFS_DRV_ROUTE);
  endfunction

  assign any_fault = fault_i.over_temp | fault_i.supply_err | fault_i.vin_under |
                     fault_i.vin_over;
  // drives must not outlive the mode: off and fail-silent cut them at the same edge
  assign drive_kill = (mode_nxt == MODE_OFF) || (mode_nxt == MODE_FAIL_SILENT);
  assign is_cfg_reg = cfg_addr(req_i.addr);
  assign cfg_locked = configuration_complete_flag_r;
  // config registers are writable only while unlocked and the interface is live
  assign cfg_wr_ok = req_i.wr && is_cfg_reg && !cfg_locked && (mode_r != MODE_OFF);
  assign ctrl_wr = req_i.wr && (req_i.addr == OFS_CONTROL) && (mode_r != MODE_OFF);

  always_comb begin
    mode_nxt = mode_r;
    if (!vin_pon_ok_i || !enable_pin_i) begin
      mode_nxt = MODE_OFF;
    end else begin
      unique case (mode_r)
        MODE_OFF: begin
          mode_nxt = MODE_CONFIG;
        end
        MODE_CONFIG: begin
          if (configuration_complete_flag_r) begin
            mode_nxt = MODE_OPERATION;
          end
        end
        MODE_OPERATION: begin
          if (any_fault) begin
            mode_nxt = MODE_FAIL_SILENT;
          end
        end
        MODE_FAIL_SILENT: begin
          // stays here until enable or input supply drops; clearing the done flag does not leave
          mode_nxt = MODE_FAIL_SILENT;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_r <= MODE_OFF;
    end else if (ce_i) begin
      mode_r <= mode_nxt;
    end
  end

  // control register: stays writable in every mode with a live interface
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      first_output_on_bit_r <= 1'b0;
      second_output_on_bit_r <= 1'b0;
      configuration_complete_flag_r <= 1'b0;
    end else if (ce_i) begin
      if (mode_r == MODE_OFF) begin
        first_output_on_bit_r <= 1'b0;
        second_output_on_bit_r <= 1'b0;
        configuration_complete_flag_r <= 1'b0;
      end else if (ctrl_wr) begin
        first_output_on_bit_r <= req_i.wdata[CTRL_OUT1_ON_BIT];
        second_output_on_bit_r <= req_i.wdata[CTRL_OUT2_ON_BIT];
        // in operation the lock holds; only fail-silent or configuration may clear it
        if (mode_r != MODE_OPERATION || req_i.wdata[CTRL_CFG_DONE_BIT]) begin
          configuration_complete_flag_r <= req_i.wdata[CTRL_CFG_DONE_BIT];
        end
      end
    end
  end

  // configuration registers; reserved bits are not stored
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phys_on_r <= RST_REG[1:0];
      physical_phase_output_map_r <= RST_REG[1:0];
      output1_virtual_phase_enables_r <= RST_REG[3:0];
      output2_virtual_phase_enables_r <= RST_REG[3:0];
      physical_phase_generator_map_r <= RST_REG[1:0];
      driver_virtual_phase_route_r <= RST_REG[3:0];
    end else if (ce_i) begin
      if (mode_r == MODE_OFF) begin
        phys_on_r <= RST_REG[1:0];
        physical_phase_output_map_r <= RST_REG[1:0];
        output1_virtual_phase_enables_r <= RST_REG[3:0];
        output2_virtual_phase_enables_r <= RST_REG[3:0];
        physical_phase_generator_map_r <= RST_REG[1:0];
        driver_virtual_phase_route_r <= RST_REG[3:0];
      end else if (cfg_wr_ok) begin
        unique case (req_i.addr)
          OFS_PHYS_ON: begin
            phys_on_r <= req_i.wdata[1:0];
          end
          OFS_PHYS_OUT_MAP: begin
            physical_phase_output_map_r <= req_i.wdata[1:0];
          end
          OFS_OUT1_VPH_EN: begin
            output1_virtual_phase_enables_r <= req_i.wdata[3:0];
          end
          OFS_OUT2_VPH_EN: begin
            output2_virtual_phase_enables_r <= req_i.wdata[3:0];
          end
          OFS_PHYS_GEN_MAP: begin
            physical_phase_generator_map_r <= req_i.wdata[1:0];
          end
          OFS_DRV_ROUTE: begin
            driver_virtual_phase_route_r <= req_i.wdata[3:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // read mux; diagnostics have no write path at all
  always_comb begin
    rd_mux = 8'h00;
    unique case (req_i.addr)
      OFS_CONTROL: begin
        rd_mux[CTRL_OUT1_ON_BIT] = first_output_on_bit_r;
        rd_mux[CTRL_OUT2_ON_BIT] = second_output_on_bit_r;
        rd_mux[CTRL_CFG_DONE_BIT] = configuration_complete_flag_r;
      end
      OFS_PHYS_ON: begin
        rd_mux = {6'h00, phys_on_r};
      end
      OFS_PHYS_OUT_MAP: begin
        rd_mux = {6'h00, physical_phase_output_map_r};
      end
      OFS_OUT1_VPH_EN: begin
        rd_mux = {4'h0, output1_virtual_phase_enables_r};
      end
      OFS_OUT2_VPH_EN: begin
        rd_mux = {4'h0, output2_virtual_phase_enables_r};
      end
      OFS_PHYS_GEN_MAP: begin
        rd_mux = {6'h00, physical_phase_generator_map_r};
      end
      OFS_DRV_ROUTE: begin
        rd_mux = {4'h0, driver_virtual_phase_route_r};
      end
      OFS_DIAG: begin
        rd_mux[DIAG_SUPPLY_GOOD_BIT] = supply_good_i;
        rd_mux[DIAG_SUPPLY_ON_BIT] = gate_supply_on_o;
        rd_mux[DIAG_MODE_LSB +: 2] = mode_r;
        rd_mux[DIAG_FAULT_LSB +: 4] = fault_i;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
    end else if (ce_i) begin
      // no answer at all while off: the interface is dead
      rvalid_o <= req_i.rd && (mode_r != MODE_OFF);
      if (req_i.rd && (mode_r != MODE_OFF)) begin
        rdata_o <= rd_mux;
      end
    end
  end

  gate_supply_seq u_seq (
    .mode_i(mode_r),
    .out_on_i({second_output_on_bit_r, first_output_on_bit_r}),
    .supply_good_i(supply_good_i),
    .supply_on_o(supply_on_c),
    .out_run_o(out_run_c)
  );

  phase_router #(
    .NUM_VPH(NUM_VPH),
    .NUM_PHYS(NUM_PHYS)
  ) u_router (
    .out1_vph_i(out1_vph_i),
    .out2_vph_i(out2_vph_i),
    .out1_vph_en_i(output1_virtual_phase_enables_r),
    .out2_vph_en_i(output2_virtual_phase_enables_r),
    .gen_map_i(physical_phase_generator_map_r),
    .route_i(driver_virtual_phase_route_r),
    .phys_on_i(phys_on_r),
    .out_map_i(physical_phase_output_map_r),
    .out_run_i(out_run_c),
    .gate_o(gate_c)
  );

  // outputs come from flops; mode_o, serial_on_o and the off/fail-silent kill follow mode_nxt, the sequenced outputs lag mode_r one cycle
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      serial_on_o <= 1'b0;
      gate_supply_on_o <= 1'b0;
      output_run_o <= 2'b00;
      gate_drive_o <= '0;
      battery_monitor_on_o <= 1'b0;
      mode_o <= MODE_OFF;
    end else if (ce_i) begin
      // supply rides through config to operation; off, fail-silent or clearing both output enable bits drop it
      serial_on_o <= (mode_nxt != MODE_OFF);
      gate_supply_on_o <= supply_on_c && !drive_kill;
      output_run_o <= drive_kill ? 2'b00 : out_run_c;
      gate_drive_o <= drive_kill ? '0 : gate_c;
      battery_monitor_on_o <= |out_run_c && !drive_kill;
      mode_o <= mode_nxt;
    end
  end

  // the controller must map each phase and keep reserved bits clear

  off_quiet_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (ce_i && (!vin_pon_ok_i || !enable_pin_i)) |=>
      (mode_r == MODE_OFF) && !serial_on_o && !gate_supply_on_o && (gate_drive_o == '0) &&
      (output_run_o == 2'b00))
    else $error("not off after supply or enable loss");

  off_no_read_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (mode_r == MODE_OFF) |=> !rvalid_o)
    else $error("read answered in off mode");

  cfg_entry_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (ce_i && mode_r == MODE_OFF && vin_pon_ok_i && enable_pin_i) |=>
      mode_r == MODE_CONFIG)
    else $error("configuration mode not entered");

  cfg_outputs_off_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (mode_r == MODE_CONFIG) ##1 (mode_r == MODE_CONFIG) |-> output_run_o == 2'b00)
    else $error("output running in configuration mode");

  lock_holds_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (ce_i && mode_r == MODE_OPERATION && mode_nxt == MODE_OPERATION) |=>
      $stable(driver_virtual_phase_route_r) && $stable(phys_on_r) &&
      $stable(output1_virtual_phase_enables_r))
    else $error("configuration changed while locked");

  supply_first_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (output_run_o != 2'b00) |-> $past(supply_good_i) && $past(mode_r) == MODE_OPERATION)
    else $error("output ran without good supply");

  fault_entry_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (ce_i && mode_r == MODE_OPERATION && any_fault && vin_pon_ok_i && enable_pin_i) |=>
      (mode_r == MODE_FAIL_SILENT) ##1 (!gate_supply_on_o || !ce_i))
    else $error("fault did not reach fail-silent with supply off");

  fail_unlock_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (ce_i && mode_r == MODE_FAIL_SILENT && ctrl_wr && !req_i.wdata[CTRL_CFG_DONE_BIT] &&
     mode_nxt == MODE_FAIL_SILENT) |=> !configuration_complete_flag_r)
    else $error("done flag not cleared in fail-silent");

  monitor_gate_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    battery_monitor_on_o |-> $past(mode_r) == MODE_OPERATION)
    else $error("battery monitor outside operation");

  cover_operation_c: cover property (@(posedge mclk_i) disable iff (!resetn_i)
    mode_r == MODE_CONFIG ##1 mode_r == MODE_OPERATION);
  cover_running_c: cover property (@(posedge mclk_i) disable iff (!resetn_i)
    output_run_o == 2'b11 && gate_drive_o != '0);
  cover_fail_c: cover property (@(posedge mclk_i) disable iff (!resetn_i)
    mode_r == MODE_OPERATION ##1 mode_r == MODE_FAIL_SILENT);
  cover_restart_c: cover property (@(posedge mclk_i) disable iff (!resetn_i)
    mode_r == MODE_FAIL_SILENT ##1 mode_r == MODE_OFF ##1 mode_r == MODE_CONFIG);

endmodule

// [boost_mode_and_phase_config_bench.sv]
// Purpose: self-checking bench for the boost mode and phase configuration block
// Assumes: partner model issues register strobes and mimics the gate supply
// Notes: random configuration and phase pulses from a fixed seed, corner cases by hand
`timescale 1ns/100ps
`define chk(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin err_total++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module boost_mode_and_phase_config_bench;
  import boost_cfg_pkg::*;
  logic mclk;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic enable = 1'b1;
  logic vin_pon = 1'b1;
  fault_s fault = '0;
  reg_req_s req;
  logic supply_good, rvalid, serial_on, supply_on, batt_on, rd_v;
  logic [3:0] vph1 = '0;
  logic [3:0] vph2 = '0;
  logic [7:0] rdata, rd_d;
  logic [1:0] run, gate;
  mode_e mode;
  int err_total = 0;
  int num_checks = 0;
  int cycles = 0;
  int seed = 32'hc7db;
  logic [7:0] cfg [6];
  logic [7:0] ofs [6] = '{OFS_PHYS_ON, OFS_PHYS_OUT_MAP, OFS_OUT1_VPH_EN, OFS_OUT2_VPH_EN,
                          OFS_PHYS_GEN_MAP, OFS_DRV_ROUTE};
  logic [7:0] msk [6] = '{MASK_TWO_BITS, MASK_TWO_BITS, MASK_FOUR_BITS, MASK_FOUR_BITS,
                          MASK_TWO_BITS, MASK_FOUR_BITS};

  boost_mode_and_phase_config boost_mode_and_phase_config_inst (
    .mclk_i(mclk), .resetn_i(resetn), .ce_i(ce), .enable_pin_i(enable),
    .vin_pon_ok_i(vin_pon), .fault_i(fault), .supply_good_i(supply_good), .req_i(req),
    .out1_vph_i(vph1), .out2_vph_i(vph2), .rdata_o(rdata), .rvalid_o(rvalid),
    .serial_on_o(serial_on), .gate_supply_on_o(supply_on), .output_run_o(run),
    .gate_drive_o(gate), .battery_monitor_on_o(batt_on), .mode_o(mode)
  );
  mcu_model mcu_model_inst (
    .mclk_i(mclk), .gate_supply_on_i(supply_on), .rdata_i(rdata), .rvalid_i(rvalid),
    .req_o(req), .supply_good_o(supply_good)
  );

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic finish_test();
    if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      finish_test();
    end
  end

  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex);
    mcu_model_inst.rd(a, rd_d, rd_v);
    `chk("rvalid", 1'b1, rd_v)
    `chk("rdata", ex, rd_d)
  endtask

  task automatic enter_op();
    mcu_model_inst.wr(OFS_CONTROL, 8'h81);
    for (int k = 0; k < 20 && mode !== MODE_OPERATION; k++) @(negedge mclk);
    `chk("mode op", MODE_OPERATION, mode)
  endtask

  // the output map drops out here; with output two stopped the caller masks its drivers itself
  function automatic logic [1:0] gate_exp(input logic [3:0] v1, input logic [3:0] v2);
    logic [1:0] g;
    logic [1:0] s;
    for (int p = 0; p < 2; p++) begin
      s = cfg[5][2*p +: 2];
      g[p] = (cfg[4][p] ? (v2[s] & cfg[3][s]) : (v1[s] & cfg[2][s])) & cfg[0][p];
    end
    return g;
  endfunction

  initial begin
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    resetn = 1'b1;
    idle(2);
    `chk("mode cfg", MODE_CONFIG, mode)
    `chk("serial", 1'b1, serial_on)
    rd_chk(OFS_DIAG, 8'h04);
    mcu_model_inst.wr(OFS_DIAG, 8'hff);
    rd_chk(OFS_DIAG, 8'h04);
    rd_chk(8'h3f, 8'h00);
    mcu_model_inst.wr(OFS_CONTROL, 8'h01);
    idle(8);
    `chk("supply cfg", 1'b1, supply_on)
    `chk("run cfg", 2'b00, run)
    mcu_model_inst.wr(OFS_CONTROL, 8'h00);
    idle(2);
    `chk("supply off", 1'b0, supply_on)
    // every physical phase gets exactly one output, reserved bits kept clear
    for (int i = 0; i < 6; i++) begin
      cfg[i] = (i == 0) ? 8'h03 : (8'($random(seed)) & msk[i]);
      mcu_model_inst.wr(ofs[i], cfg[i]);
    end
    for (int i = 0; i < 6; i++) rd_chk(ofs[i], cfg[i]);
    mcu_model_inst.wr(OFS_CONTROL, 8'h83);
    `chk("run early", 2'b00, run)
    for (int k = 0; k < 20 && run !== 2'b11; k++) @(negedge mclk);
    `chk("run", 2'b11, run)
    `chk("supply good", 1'b1, supply_good)
    `chk("battery", 1'b1, batt_on)
    mcu_model_inst.wr(OFS_CONTROL, 8'h03);
    rd_chk(OFS_CONTROL, 8'h83);
    mcu_model_inst.wr(ofs[5], ~cfg[5] & msk[5]);
    rd_chk(ofs[5], cfg[5]);
    ce = 1'b0;
    mcu_model_inst.wr(OFS_CONTROL, 8'h00);
    `chk("run frozen", 2'b11, run)
    ce = 1'b1;
    rd_chk(OFS_CONTROL, 8'h83);
    repeat (16) begin
      vph1 = 4'($random(seed));
      vph2 = 4'($random(seed));
      idle(3);
      `chk("gate", gate_exp(vph1, vph2), gate)
    end
    // output two stopped: drivers mapped to it fall silent
    mcu_model_inst.wr(OFS_CONTROL, 8'h01);
    idle(3);
    `chk("gate one out", gate_exp(vph1, vph2) & ~cfg[1][1:0], gate)
    mcu_model_inst.wr(OFS_CONTROL, 8'h03);
    for (int i = 0; i < 4; i++) begin
      fault = fault_s'(4'h1 << i);
      idle(2);
      `chk("mode fail", MODE_FAIL_SILENT, mode)
      `chk("run fail", 2'b00, run)
      `chk("supply fail", 1'b0, supply_on)
      `chk("battery fail", 1'b0, batt_on)
      fault = '0;
      rd_chk(OFS_CONTROL, (i == 0) ? 8'h83 : 8'h81);
      mcu_model_inst.wr(OFS_CONTROL, 8'h01);
      mcu_model_inst.wr(OFS_OUT1_VPH_EN, 8'h05);
      rd_chk(OFS_OUT1_VPH_EN, 8'h05);
      `chk("mode held", MODE_FAIL_SILENT, mode)
      if (i[0]) vin_pon = 1'b0;
      else enable = 1'b0;
      idle(2);
      `chk("mode off", MODE_OFF, mode)
      `chk("serial off", 1'b0, serial_on)
      mcu_model_inst.rd(OFS_CONTROL, rd_d, rd_v);
      `chk("no answer", 1'b0, rd_v)
      vin_pon = 1'b1;
      enable = 1'b1;
      idle(2);
      `chk("mode restart", MODE_CONFIG, mode)
      rd_chk(OFS_OUT1_VPH_EN, 8'h00);
      enter_op();
    end
    for (int k = 0; k < 20 && run !== 2'b01; k++) @(negedge mclk);
    `chk("run again", 2'b01, run)
    enable = 1'b0;
    idle(1);
    `chk("run drop", 2'b00, run)
    `chk("gate drop", 2'b00, gate)
    `chk("supply drop", 1'b0, supply_on)
    finish_test();
  end
endmodule

// [gate_supply_seq.sv]
// Purpose: gate-drive supply and output start-up sequencing per mode
// Assumes: supply good comes from the analog regulator, synchronous to the clock
// Notes: purely combinational; the top registers the results
`timescale 1ns/100ps
module gate_supply_seq (
  input wire boost_cfg_pkg::mode_e mode_i,
  input wire logic [1:0] out_on_i,
  input wire logic supply_good_i,
  output logic supply_on_o,
  output logic [1:0] out_run_o
);
  import boost_cfg_pkg::*;

  always_comb begin
    supply_on_o = 1'b0;
    out_run_o = 2'b00;
    unique case (mode_i)
      MODE_OFF: begin
        supply_on_o = 1'b0;
      end
      MODE_CONFIG: begin
        supply_on_o = |out_on_i;
      end
      MODE_OPERATION: begin
        supply_on_o = |out_on_i;
        // outputs wait for the regulator so fets never see a weak gate drive
        out_run_o = supply_good_i ? out_on_i : 2'b00;
      end
      MODE_FAIL_SILENT: begin
        supply_on_o = 1'b0;
      end
    endcase
  end
endmodule

// [mcu_model.sv]
// Purpose: controller-side model issuing register strobes, plus the gate supply regulator
// Assumes: strobes launched on the falling edge, one access per call
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/100ps
module mcu_model (
  input wire logic mclk_i,
  input wire logic gate_supply_on_i,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  output boost_cfg_pkg::reg_req_s req_o,
  output logic supply_good_o
);
  import boost_cfg_pkg::*;
  int good_delay = 3;
  int ramp = 0;

  initial begin
    req_o = '0;
    supply_good_o = 1'b0;
  end

  // regulator ramps only while asked for, drops at once when released
  always @(posedge mclk_i) begin
    if (!gate_supply_on_i) begin
      ramp <= 0;
      supply_good_o <= 1'b0;
    end else if (ramp >= good_delay) begin
      supply_good_o <= 1'b1;
    end else begin
      ramp <= ramp + 1;
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    req_o <= '{1'b1, 1'b0, a, d};
    @(negedge mclk_i);
    req_o <= '{1'b0, 1'b0, ~a, ~d};
  endtask

  // the answer stands only for the cycle after the taking edge, so it is taken there
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge mclk_i);
    req_o <= '{1'b0, 1'b1, a, 8'h00};
    @(negedge mclk_i);
    d = rdata_i;
    v = rvalid_i;
    req_o <= '{1'b0, 1'b0, ~a, 8'hff};
  endtask
endmodule

// [phase_router.sv]
// Purpose: maps virtual phases of two virtual outputs onto the physical gate drivers
// Assumes: virtual phase pulses come from the timing generator, one bit per phase
// Notes: combinational; the top registers the gate outputs
`timescale 1ns/100ps
module phase_router #(
  parameter int NUM_VPH = 4,
  parameter int NUM_PHYS = 2
) (
  input wire logic [NUM_VPH-1:0] out1_vph_i,
  input wire logic [NUM_VPH-1:0] out2_vph_i,
  input wire logic [NUM_VPH-1:0] out1_vph_en_i,
  input wire logic [NUM_VPH-1:0] out2_vph_en_i,
  input wire logic [NUM_PHYS-1:0] gen_map_i,
  input wire logic [2*NUM_PHYS-1:0] route_i,
  input wire logic [NUM_PHYS-1:0] phys_on_i,
  input wire logic [NUM_PHYS-1:0] out_map_i,
  input wire logic [1:0] out_run_i,
  output logic [NUM_PHYS-1:0] gate_o
);
  logic [NUM_VPH-1:0] vph1;
  logic [NUM_VPH-1:0] vph2;

  assign vph1 = out1_vph_i & out1_vph_en_i;
  assign vph2 = out2_vph_i & out2_vph_en_i;

  for (genvar g = 0; g < NUM_PHYS; g++) begin : g_drv
    logic [1:0] sel;
    logic pulse;
    assign sel = route_i[2*g +: 2];
    assign pulse = gen_map_i[g] ? vph2[sel] : vph1[sel];
    // a driver fires only while the output it regulates is running
    assign gate_o[g] = pulse & phys_on_i[g] & out_run_i[out_map_i[g]];
  end
endmodule
